/* src/scim_monitor.sv */
// Supply and clock integrity monitor with its APB control and status register
// Behaviour
// - While supply is low, hold core in reset and pull the reset pin low.
// - Leave low-voltage reset on rising threshold, enter it on falling threshold.
// - Low-voltage reset acts only when enabled by the option setting.
// - Supply warning flag follows its comparator live; software writes are ignored.
// - Warning flag reads 0 above rising threshold, 1 below falling threshold.
// - Warning logic is inert unless low-voltage reset option is enabled.
// - With warning interrupt enabled, every flag change raises a request.
// - Warning enable at bit 6 read/write; pending clears on service entry.
// - No warning interrupt for changes seen during the reset delay.
// - Enabling while flag shows low raises one request, crossing raises another.
// - Enabling after flag cleared gives only later crossing requests.
// - Clock glitch filter runs only with the frequency doubler enabled.
// - Lost main clock selects safe oscillator; recovery switches back automatically.
// - Clock-loss flag bit 1 set by hardware, cleared by read after recovery.
// - Clock-loss flag forced to 0 when clock guard option is off.
// - Clock-loss enable bit 2 read/write; no effect with guard option off.
// - Interrupts need own enable set and the global mask cleared.
// - These interrupts wake from wait mode but never from halt.
// - Halt disables guard and safe oscillator; configuration resumes on exit.
// - Low-voltage reset flag bit 4 set by hardware, cleared by writing zero.
// - Register resets to all zeros with both reset flags resolved to zero.
// - Watchdog flag bit 0 set on watchdog reset, cleared by zero write or low voltage.
// - Low-voltage flag survives later watchdog resets; rst_n clears it.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
module scim_monitor
    import scim_pkg::*;
#(
    parameter int DELAY_SHORT = SCIM_DELAY_SHORT,
    parameter int DELAY_LONG = SCIM_DELAY_LONG
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [SCIM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire scim_opt_t opt,
    input wire logic supply_below_rise,
    input wire logic supply_below_fall,
    input wire logic supply_warn_low,
    input wire logic main_osc_lost,
    input wire logic wdg_reset_evt,
    input wire logic halt_mode,
    input wire logic wait_mode,
    input wire logic irq_global_mask,
    input wire logic warn_irq_ack,
    output logic reset_pin_out,
    output logic reset_pin_oe_n,
    output logic core_reset,
    output logic safe_osc_sel,
    output logic clock_filter_en,
    output logic warn_irq,
    output logic clock_loss_irq,
    output logic wait_wake
);

    localparam int CNT_W = $clog2(DELAY_LONG + 1);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [SCIM_SYNC_N-1:0] async_in;
    logic [SCIM_SYNC_N-1:0] sync1_reg;
    logic [SCIM_SYNC_N-1:0] sync2_reg;

    assign async_in = {main_osc_lost, supply_warn_low, supply_below_fall, supply_below_rise};

    genvar gi;
    generate
        for (gi = 0; gi < SCIM_SYNC_N; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= async_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    logic below_rise_s;
    logic below_fall_s;
    logic warn_s;
    logic osc_lost_s;

    assign below_rise_s = sync2_reg[SCIM_IN_BELOW_RISE];
    assign below_fall_s = sync2_reg[SCIM_IN_BELOW_FALL];
    assign warn_s = sync2_reg[SCIM_IN_WARN];
    assign osc_lost_s = sync2_reg[SCIM_IN_OSC_LOST];

    // ****************************************
    // Low-voltage reset sequence
    // ****************************************
    scim_state_t state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] delay_last;
    logic in_reset;
    logic lvd_hit;

    assign delay_last = opt.long_delay ? CNT_W'(DELAY_LONG - 1) : CNT_W'(DELAY_SHORT - 1);
    assign in_reset = (state_reg != SCIM_ST_RUN);
    assign lvd_hit = (state_reg == SCIM_ST_LOW);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= SCIM_ST_RUN;
            cnt_reg <= '0;
        end else begin
            case (state_reg)
                SCIM_ST_RUN: begin
                    if (opt.lvd_en && below_fall_s) begin
                        state_reg <= SCIM_ST_LOW;
                    end
                end
                SCIM_ST_LOW: begin
                    // Hysteresis: only the higher threshold, or opt.lvd_en going low, lets the core out
                    if (!opt.lvd_en) begin
                        state_reg <= SCIM_ST_RUN;
                    end else if (!below_rise_s) begin
                        state_reg <= SCIM_ST_DELAY;
                        cnt_reg <= '0;
                    end
                end
                SCIM_ST_DELAY: begin
                    if (opt.lvd_en && below_fall_s) begin
                        state_reg <= SCIM_ST_LOW;
                    end else if (cnt_reg == delay_last) begin
                        state_reg <= SCIM_ST_RUN;
                    end else begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                default: begin
                    state_reg <= SCIM_ST_RUN;
                end
            endcase
        end
    end

    // Pin is open drain: it only ever pulls low, so the level stays zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reset_pin_out <= 1'b0;
            reset_pin_oe_n <= 1'b1;
            core_reset <= 1'b0;
        end else begin
            reset_pin_out <= 1'b0;
            reset_pin_oe_n <= !in_reset;
            core_reset <= in_reset;
        end
    end

    // ****************************************
    // APB slave
    // ****************************************
    scim_ctrl_t ctrl_reg;
    logic warn_flag_reg;
    logic warn_prev_reg;
    logic clk_lost_reg;
    logic warn_pend_reg;
    logic sel_setup;
    logic acc_done;
    logic hit;
    logic wr_ok;
    logic rd_ok;
    logic [7:0] ics_read;

    assign sel_setup = psel && !penable;
    assign acc_done = psel && penable && pready;
    assign hit = (paddr == SCIM_OFS_ICS);
    assign wr_ok = acc_done && pwrite && hit;
    assign rd_ok = acc_done && !pwrite && hit;

    // Reserved bits read as zero
    always_comb begin
        ics_read = SCIM_ICS_RESET;
        ics_read[SCIM_BIT_WARN_IE] = ctrl_reg.warn_ie;
        ics_read[SCIM_BIT_WARN_F] = warn_flag_reg;
        ics_read[SCIM_BIT_LVD_RF] = ctrl_reg.lvd_rf;
        ics_read[SCIM_BIT_CLK_IE] = ctrl_reg.clk_ie;
        ics_read[SCIM_BIT_CLK_LOST] = clk_lost_reg;
        ics_read[SCIM_BIT_WDG_RF] = ctrl_reg.wdg_rf;
    end

    // No wait state: data is latched in setup, so every output is a flop
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= sel_setup;
            pslverr <= sel_setup && !hit;
            prdata <= (sel_setup && hit && !pwrite) ? {24'h000000, ics_read} : 32'h00000000;
        end
    end

    // ****************************************
    // Control and reset flags
    // ****************************************
    // Enables take reset values while the core is held in reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg.warn_ie <= 1'b0;
            ctrl_reg.clk_ie <= 1'b0;
        end else if (in_reset) begin
            ctrl_reg.warn_ie <= 1'b0;
            ctrl_reg.clk_ie <= 1'b0;
        end else if (wr_ok) begin
            // Bits 7 and 3 have no storage, so a stray one is harmless
            ctrl_reg.warn_ie <= pwdata[SCIM_BIT_WARN_IE];
            ctrl_reg.clk_ie <= pwdata[SCIM_BIT_CLK_IE];
        end
    end

    // Watchdog resets do not touch this flag, so the first failure stays visible
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg.lvd_rf <= 1'b0;
        end else if (lvd_hit) begin
            ctrl_reg.lvd_rf <= 1'b1;
        end else if (wr_ok && !pwdata[SCIM_BIT_LVD_RF]) begin
            ctrl_reg.lvd_rf <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg.wdg_rf <= 1'b0;
        end else if (wdg_reset_evt) begin
            ctrl_reg.wdg_rf <= 1'b1;
        end else if (lvd_hit) begin
            ctrl_reg.wdg_rf <= 1'b0;
        end else if (wr_ok && !pwdata[SCIM_BIT_WDG_RF]) begin
            ctrl_reg.wdg_rf <= 1'b0;
        end
    end

    // ****************************************
    // Supply warning
    // ****************************************
    logic warn_toggle;
    logic warn_enable_low;

    // A drop caused by switching the option off is not a supply event
    assign warn_toggle = opt.lvd_en && (warn_flag_reg != warn_prev_reg);
    assign warn_enable_low = wr_ok && pwdata[SCIM_BIT_WARN_IE] && !ctrl_reg.warn_ie
        && warn_flag_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            warn_flag_reg <= 1'b0;
            warn_prev_reg <= 1'b0;
        end else begin
            warn_flag_reg <= opt.lvd_en && warn_s;
            warn_prev_reg <= warn_flag_reg;
        end
    end

    // Set wins over the service acknowledge in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            warn_pend_reg <= 1'b0;
        end else if (in_reset) begin
            warn_pend_reg <= 1'b0;
        end else if ((ctrl_reg.warn_ie && warn_toggle) || warn_enable_low) begin
            warn_pend_reg <= 1'b1;
        end else if (warn_irq_ack) begin
            warn_pend_reg <= 1'b0;
        end
    end

    // ****************************************
    // Clock guard
    // ****************************************
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            safe_osc_sel <= 1'b0;
            clock_filter_en <= 1'b0;
        end else begin
            safe_osc_sel <= opt.css_en && !halt_mode && osc_lost_s;
            clock_filter_en <= opt.css_en && opt.pll_en && !halt_mode;
        end
    end

    // Frozen in halt; a read only clears once the main clock is back
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clk_lost_reg <= 1'b0;
        end else if (!opt.css_en) begin
            clk_lost_reg <= 1'b0;
        end else if (halt_mode) begin
            clk_lost_reg <= clk_lost_reg;
        end else if (safe_osc_sel) begin
            clk_lost_reg <= 1'b1;
        end else if (rd_ok && !osc_lost_s) begin
            clk_lost_reg <= 1'b0;
        end
    end

    // ****************************************
    // Interrupt requests and wake
    // ****************************************
    logic warn_irq_c;
    logic clk_irq_c;

    assign warn_irq_c = warn_pend_reg && ctrl_reg.warn_ie && !irq_global_mask;
    assign clk_irq_c = clk_lost_reg && ctrl_reg.clk_ie && opt.css_en && !irq_global_mask;

    // Halt wake is deliberately absent: these sources cannot leave halt
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            warn_irq <= 1'b0;
            clock_loss_irq <= 1'b0;
            wait_wake <= 1'b0;
        end else begin
            warn_irq <= warn_irq_c;
            clock_loss_irq <= clk_irq_c;
            wait_wake <= wait_mode && !halt_mode && (warn_irq_c || clk_irq_c);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_low_entry;
        state_reg == SCIM_ST_RUN ##1 state_reg == SCIM_ST_LOW;
    endsequence

    sequence s_ack_only;
        warn_pend_reg && warn_irq_ack && !in_reset && !warn_toggle && !wr_ok;
    endsequence

    property p_lvd_pin;
        @(posedge clock) disable iff (!rst_n)
        s_low_entry |=> !reset_pin_oe_n && core_reset;
    endproperty
    a_lvd_pin: assert property (p_lvd_pin) else $error("reset pin not pulled low");

    property p_lvd_hyst;
        @(posedge clock) disable iff (!rst_n)
        lvd_hit && opt.lvd_en && below_rise_s |=> lvd_hit;
    endproperty
    a_lvd_hyst: assert property (p_lvd_hyst) else $error("left reset below rise level");

    property p_lvd_off;
        @(posedge clock) disable iff (!rst_n)
        !opt.lvd_en |=> !lvd_hit;
    endproperty
    a_lvd_off: assert property (p_lvd_off) else $error("low-voltage reset while disabled");

    property p_warn_follow;
        @(posedge clock) disable iff (!rst_n)
        (opt.lvd_en && warn_s) [*2] |=> warn_flag_reg;
    endproperty
    a_warn_follow: assert property (p_warn_follow) else $error("warning flag not following");

    property p_warn_gate;
        @(posedge clock) disable iff (!rst_n)
        !opt.lvd_en |=> !warn_flag_reg;
    endproperty
    a_warn_gate: assert property (p_warn_gate) else $error("warning active while disabled");

    property p_warn_toggle;
        @(posedge clock) disable iff (!rst_n)
        warn_toggle && ctrl_reg.warn_ie && !in_reset |=> warn_pend_reg;
    endproperty
    a_warn_toggle: assert property (p_warn_toggle) else $error("flag change not requested");

    property p_warn_ack;
        @(posedge clock) disable iff (!rst_n)
        s_ack_only |=> !warn_pend_reg;
    endproperty
    a_warn_ack: assert property (p_warn_ack) else $error("pending not cleared by service");

    property p_warn_delay;
        @(posedge clock) disable iff (!rst_n)
        in_reset |=> !warn_pend_reg ##1 !warn_irq;
    endproperty
    a_warn_delay: assert property (p_warn_delay) else $error("warning during reset delay");

    property p_warn_enable;
        @(posedge clock) disable iff (!rst_n)
        warn_enable_low && !in_reset |=> warn_pend_reg;
    endproperty
    a_warn_enable: assert property (p_warn_enable) else $error("no request on enable");

    property p_safe_osc;
        @(posedge clock) disable iff (!rst_n)
        opt.css_en && !halt_mode && osc_lost_s |=> safe_osc_sel;
    endproperty
    a_safe_osc: assert property (p_safe_osc) else $error("safe oscillator not selected");

    property p_clk_flag;
        @(posedge clock) disable iff (!rst_n)
        safe_osc_sel && opt.css_en && !halt_mode |=> clk_lost_reg;
    endproperty
    a_clk_flag: assert property (p_clk_flag) else $error("clock-loss flag not set");

    property p_clk_off;
        @(posedge clock) disable iff (!rst_n)
        !opt.css_en |=> !clk_lost_reg ##1 !clock_loss_irq;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock-loss active while disabled");

    property p_mask;
        @(posedge clock) disable iff (!rst_n)
        warn_irq || clock_loss_irq |-> $past(!irq_global_mask);
    endproperty
    a_mask: assert property (p_mask) else $error("interrupt while masked");

    property p_lvd_flag;
        @(posedge clock) disable iff (!rst_n)
        lvd_hit |=> ctrl_reg.lvd_rf;
    endproperty
    a_lvd_flag: assert property (p_lvd_flag) else $error("low-voltage flag not set");

    property p_wdg_flag;
        @(posedge clock) disable iff (!rst_n)
        wdg_reset_evt |=> ctrl_reg.wdg_rf;
    endproperty
    a_wdg_flag: assert property (p_wdg_flag) else $error("watchdog flag not set");

endmodule

/* src/scim_pkg.sv */
// Package for the supply and clock integrity monitor: map, fields, states and counts
package scim_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int SCIM_ADDR_W = 12;
    localparam logic [11:0] SCIM_OFS_ICS = 12'h000;
    localparam logic [7:0] SCIM_ICS_RESET = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int SCIM_BIT_WARN_IE = 6;
    localparam int SCIM_BIT_WARN_F = 5;
    localparam int SCIM_BIT_LVD_RF = 4;
    localparam int SCIM_BIT_CLK_IE = 2;
    localparam int SCIM_BIT_CLK_LOST = 1;
    localparam int SCIM_BIT_WDG_RF = 0;

    // ****************************************
    // Counts
    // ****************************************
    localparam int SCIM_DELAY_SHORT = 256;
    localparam int SCIM_DELAY_LONG = 4096;
    localparam int SCIM_SYNC_N = 4;
    localparam int SCIM_SYNC_STAGES = 2;
    localparam int SCIM_IN_BELOW_RISE = 0;
    localparam int SCIM_IN_BELOW_FALL = 1;
    localparam int SCIM_IN_WARN = 2;
    localparam int SCIM_IN_OSC_LOST = 3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        SCIM_ST_RUN = 3'b001,
        SCIM_ST_LOW = 3'b010,
        SCIM_ST_DELAY = 3'b100
    } scim_state_t;

    typedef struct packed {
        logic warn_ie;
        logic clk_ie;
        logic lvd_rf;
        logic wdg_rf;
    } scim_ctrl_t;

    typedef struct packed {
        logic lvd_en;
        logic css_en;
        logic pll_en;
        logic long_delay;
    } scim_opt_t;

endpackage

/* sim/scim_monitor_tb.sv */
// Self-checking testbench for the supply and clock integrity monitor
`timescale 1ns/1ns
module scim_monitor_tb;
    import scim_pkg::*;
    // ****************************************
    // Stimulus and observation
    // ****************************************
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [SCIM_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    scim_opt_t opt = '0;
    logic supply_below_rise = 1'b0;
    logic supply_below_fall = 1'b0;
    logic supply_warn_low = 1'b0;
    logic main_osc_lost = 1'b0;
    logic wdg_reset_evt = 1'b0;
    logic halt_mode = 1'b0;
    logic wait_mode = 1'b0;
    logic irq_global_mask = 1'b0;
    logic warn_irq_ack = 1'b0;
    logic reset_pin_out, reset_pin_oe_n, core_reset, safe_osc_sel;
    logic clock_filter_en, warn_irq, clock_loss_irq, wait_wake;
    int num_errors = 0;
    int n_tests = 0;

    always #10 clock = ~clock;

    // Short delays keep the run brief; expectations follow these values
    scim_monitor #(.DELAY_SHORT(4), .DELAY_LONG(8)) i_dut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .opt(opt), .supply_below_rise(supply_below_rise),
        .supply_below_fall(supply_below_fall), .supply_warn_low(supply_warn_low),
        .main_osc_lost(main_osc_lost), .wdg_reset_evt(wdg_reset_evt),
        .halt_mode(halt_mode), .wait_mode(wait_mode), .irq_global_mask(irq_global_mask),
        .warn_irq_ack(warn_irq_ack), .reset_pin_out(reset_pin_out),
        .reset_pin_oe_n(reset_pin_oe_n), .core_reset(core_reset),
        .safe_osc_sel(safe_osc_sel), .clock_filter_en(clock_filter_en),
        .warn_irq(warn_irq), .clock_loss_irq(clock_loss_irq), .wait_wake(wait_wake)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        if (num_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic sg(input int i);
        case (i)
            0: return core_reset;
            1: return reset_pin_oe_n;
            2: return safe_osc_sel;
            3: return clock_filter_en;
            4: return warn_irq;
            5: return clock_loss_irq;
            default: return wait_wake;
        endcase
    endfunction

    // Waits a bounded number of edges for an output to reach a level
    task automatic wt(input int i, input logic v, input int lim);
        int k;
        k = 0;
        while (sg(i) !== v && k < lim) begin
            @(posedge clock);
            k++;
        end
        chk({31'h0, sg(i)}, {31'h0, v});
    endtask

    // Output must keep its level for n edges
    task automatic hold(input int i, input logic v, input int n);
        repeat (n) begin
            @(posedge clock);
            chk({31'h0, sg(i)}, {31'h0, v});
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, SCIM_OFS_ICS, {24'h0, d}, r, e);
    endtask

    task automatic rd(input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, SCIM_OFS_ICS, 32'h0, r, e);
        chk(r, {24'h0, exp});
    endtask

    task automatic pulse_wdg();
        wdg_reset_evt <= 1'b1;
        @(posedge clock);
        wdg_reset_evt <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task automatic ack();
        warn_irq_ack <= 1'b1;
        @(posedge clock);
        warn_irq_ack <= 1'b0;
        wt(4, 1'b0, 4);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_reset_and_bus();
        logic [31:0] r;
        logic e;
        rd(8'h00);
        chk({31'h0, reset_pin_oe_n}, 32'h1);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        wr(8'h33);
        rd(8'h00);
        wr(8'h44);
        rd(8'h44);
        wr(8'h00);
        opt.css_en <= 1'b1;
        opt.pll_en <= 1'b1;
        wt(3, 1'b1, 6);
        opt.pll_en <= 1'b0;
        wt(3, 1'b0, 6);
        opt.css_en <= 1'b0;
    endtask

    task automatic sc_low_voltage();
        opt.lvd_en <= 1'b0;
        supply_below_rise <= 1'b1;
        supply_below_fall <= 1'b1;
        hold(0, 1'b0, 8);
        supply_below_fall <= 1'b0;
        supply_below_rise <= 1'b0;
        // Let the low levels clear the synchronisers before enabling
        repeat (3) @(posedge clock);
        opt.lvd_en <= 1'b1;
        pulse_wdg();
        rd(8'h01);
        supply_below_rise <= 1'b1;
        supply_below_fall <= 1'b1;
        wt(0, 1'b1, 8);
        chk({31'h0, reset_pin_oe_n}, 32'h0);
        chk({31'h0, reset_pin_out}, 32'h0);
        supply_below_fall <= 1'b0;
        hold(0, 1'b1, 8);
        supply_below_rise <= 1'b0;
        wt(0, 1'b0, 16);
        chk({31'h0, reset_pin_oe_n}, 32'h1);
        rd(8'h10);
        pulse_wdg();
        rd(8'h11);
        opt.long_delay <= 1'b1;
        supply_below_rise <= 1'b1;
        supply_below_fall <= 1'b1;
        wt(0, 1'b1, 8);
        supply_below_fall <= 1'b0;
        supply_below_rise <= 1'b0;
        // Two sync edges, one to leave LOW, eight of delay, one to register
        hold(0, 1'b1, 12);
        hold(0, 1'b0, 1);
        opt.long_delay <= 1'b0;
        wr(8'h00);
        rd(8'h00);
    endtask

    task automatic sc_warning();
        logic [31:0] r;
        logic e;
        wr(8'h40);
        hold(4, 1'b0, 4);
        wr(8'h00);
        supply_warn_low <= 1'b1;
        hold(4, 1'b0, 8);
        rd(8'h20);
        wr(8'h40);
        wt(4, 1'b1, 6);
        ack();
        supply_warn_low <= 1'b0;
        wt(4, 1'b1, 10);
        ack();
        rd(8'h40);
        irq_global_mask <= 1'b1;
        supply_warn_low <= 1'b1;
        hold(4, 1'b0, 10);
        irq_global_mask <= 1'b0;
        wt(4, 1'b1, 4);
        ack();
        opt.lvd_en <= 1'b0;
        repeat (8) @(posedge clock);
        chk({31'h0, warn_irq}, 32'h0);
        apb(1'b0, SCIM_OFS_ICS, 32'h0, r, e);
        chk(r & 32'hEF, 32'h40);
        supply_warn_low <= 1'b0;
        repeat (3) @(posedge clock);
        opt.lvd_en <= 1'b1;
        wr(8'h00);
        repeat (8) @(posedge clock);
    endtask

    task automatic sc_clock_guard();
        opt.css_en <= 1'b1;
        wr(8'h04);
        main_osc_lost <= 1'b1;
        wt(2, 1'b1, 8);
        wt(5, 1'b1, 6);
        wait_mode <= 1'b1;
        wt(6, 1'b1, 6);
        wait_mode <= 1'b0;
        rd(8'h06);
        rd(8'h06);
        halt_mode <= 1'b1;
        wt(2, 1'b0, 6);
        halt_mode <= 1'b0;
        wt(2, 1'b1, 6);
        main_osc_lost <= 1'b0;
        wt(2, 1'b0, 8);
        repeat (4) @(posedge clock);
        rd(8'h06);
        rd(8'h04);
        wt(5, 1'b0, 4);
        main_osc_lost <= 1'b1;
        opt.css_en <= 1'b0;
        repeat (8) @(posedge clock);
        rd(8'h04);
        chk({31'h0, clock_loss_irq}, 32'h0);
        main_osc_lost <= 1'b0;
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        sc_reset_and_bus();
        sc_low_voltage();
        sc_warning();
        sc_clock_guard();
        end_of_test();
    end

    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        end_of_test();
    end
endmodule
